// ===== pcwb_defs.vh
// Constants shared by the card window bridge: index map, window field layout, lanes.
// Assumes one host clock domain; included by bare name from the window and bridge design files.
`ifndef PCWB_DEFS_VH
`define PCWB_DEFS_VH

// Socket and window counts
`define PCWB_NSOCK_MAX    4
`define PCWB_NSOCK_TWO    3'd2
`define PCWB_NSOCK_FOUR   3'd4
`define PCWB_NUM_WIN      5

// Index byte layout
`define PCWB_SOCK_FIELD   7:6
`define PCWB_REG_FIELD    5:0

// Register offsets inside one socket
`define PCWB_OFF_ID       6'h00
`define PCWB_OFF_STAT     6'h01
`define PCWB_OFF_PAGE     6'h05
`define PCWB_OFF_WEN      6'h06
`define PCWB_OFF_LAST     6'h37
`define PCWB_WIN_GROUP    5:3
`define PCWB_WIN_SEL      2:0
`define PCWB_WIN_FIRST    3'd2

// Window register selects
`define PCWB_WSEL_START_LO 3'd0
`define PCWB_WSEL_START_HI 3'd1
`define PCWB_WSEL_STOP_LO  3'd2
`define PCWB_WSEL_STOP_HI  3'd3
`define PCWB_WSEL_OFF_LO   3'd4
`define PCWB_WSEL_OFF_HI   3'd5

// Window field layout
`define PCWB_ADDR_HI      3:0
`define PCWB_WIDTH_BIT    7
`define PCWB_TIMING       7:6
`define PCWB_WP_BIT       7
`define PCWB_ATTR_BIT     6
`define PCWB_OFFS_HI      5:0

// Host address fields
`define PCWB_PAGE_FIELD   31:24
`define PCWB_WIN_FIELD    23:12
`define PCWB_BYTE_FIELD   11:0
`define PCWB_WORD_FIELD   31:2
`define PCWB_LANE_FIELD   1:0
`define PCWB_LANE_LAST    2'd3

// Status register bits
`define PCWB_STAT_MODE    7
`define PCWB_STAT_IDXV    0

// Strap capture delay after reset release
`define PCWB_STRAP_WAIT   2'd2

`endif

// ===== pcwb_ram.v
// Byte-wide storage for socket registers that steer no logic here.
// Assumes one write and one read per cycle; read data come from a register.
`timescale 1ns/100ps

module pcwb_ram
#(
   parameter AW = 8,
   parameter DW = 8
)
(
   input  wire          clk_sys,
   input  wire          nrst,
   input  wire          ce,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire          re,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Array is not reset; unwritten bytes read back undefined
   always @(posedge clk_sys)
   begin
      if (ce && we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         rdata <= {DW{1'b0}};
      end
      else if (ce && re)
      begin
         rdata <= mem[raddr];
      end
   end

endmodule

// ===== pcwb_window.v
// One memory mapping window: its six registers, host address compare and card address.
// Assumes writes arrive already decoded to this window; page and enable come from outside.
`timescale 1ns/100ps
`include "pcwb_defs.vh"

module pcwb_window
(
   input  wire        clk_sys,
   input  wire        nrst,
   input  wire        ce,
   input  wire        wr_en,
   input  wire [2:0]  sel,
   input  wire [7:0]  wdata,
   input  wire        enable,
   input  wire [7:0]  page,
   input  wire [31:0] haddr,
   output wire        hit,
   output wire [13:0] card_hi,
   output wire        attr,
   output wire        width16,
   output wire [1:0]  timing,
   output wire        wp,
   output reg  [7:0]  rdata
);

   reg  [7:0]  start_lo;
   reg  [7:0]  start_hi;
   reg  [7:0]  stop_lo;
   reg  [7:0]  stop_hi;
   reg  [7:0]  off_lo;
   reg  [7:0]  off_hi;
   wire [11:0] start_a;
   wire [11:0] stop_a;
   wire [11:0] host_a;

   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         start_lo <= 8'h00;
         start_hi <= 8'h00;
         stop_lo  <= 8'h00;
         stop_hi  <= 8'h00;
         off_lo   <= 8'h00;
         off_hi   <= 8'h00;
      end
      else if (ce && wr_en)
      begin
         case (sel)
            `PCWB_WSEL_START_LO: start_lo <= wdata;
            `PCWB_WSEL_START_HI: start_hi <= wdata;
            `PCWB_WSEL_STOP_LO:  stop_lo  <= wdata;
            `PCWB_WSEL_STOP_HI:  stop_hi  <= wdata;
            `PCWB_WSEL_OFF_LO:   off_lo   <= wdata;
            `PCWB_WSEL_OFF_HI:   off_hi   <= wdata;
            default:             off_hi   <= off_hi;
         endcase
      end
   end

   always @*
   begin
      case (sel)
         `PCWB_WSEL_START_LO: rdata = start_lo;
         `PCWB_WSEL_START_HI: rdata = start_hi;
         `PCWB_WSEL_STOP_LO:  rdata = stop_lo;
         `PCWB_WSEL_STOP_HI:  rdata = stop_hi;
         `PCWB_WSEL_OFF_LO:   rdata = off_lo;
         `PCWB_WSEL_OFF_HI:   rdata = off_hi;
         default:             rdata = 8'h00;
      endcase
   end

   // Start and stop count 4 KByte steps inside one 16 MByte page
   assign start_a = {start_hi[`PCWB_ADDR_HI], start_lo}; // R10
   assign stop_a  = {stop_hi[`PCWB_ADDR_HI], stop_lo}; // R10
   assign host_a  = haddr[`PCWB_WIN_FIELD];
   assign hit     = enable && (haddr[`PCWB_PAGE_FIELD] == page) && (host_a >= start_a) && (host_a <= stop_a); // R17
   // Offset is 14 bits of 4 KByte steps, so the card space wraps at 64 MByte
   assign card_hi = {off_hi[`PCWB_OFFS_HI], off_lo} + {2'b00, host_a}; // R13
   assign attr    = off_hi[`PCWB_ATTR_BIT]; // R15
   assign width16 = start_hi[`PCWB_WIDTH_BIT]; // R9
   assign timing  = stop_hi[`PCWB_TIMING]; // R9
   assign wp      = off_hi[`PCWB_WP_BIT]; // R9

endmodule

// ===== pcwb_bridge.v
// Index/data register front end and memory window decode for the card socket bridge.
// Assumes bridge_base comes from same-clock configuration logic; strap is an asynchronous pin.
`timescale 1ns/100ps
`include "pcwb_defs.vh"

// Notes on behaviour
// [R1] Index port sits at bridge_base, data port at the next byte address; with bridge_base in lane 3 the code decodes no data port.
// [R2] Data port accesses reach the register the stored index selects.
// [R3] One 16-bit write stores index from bits 7:0, data from bits 15:8.
// [R4] No data access and no index read is claimed before a valid index.
// [R5] Index and data ports are both readable and writable.
// [R6] Config space holds setup, interrupt, I/O mapping and memory mapping groups.
// [R7] Each socket has five independent memory windows.
// [R8] Windows reach 64 MByte common and 64 MByte attribute card memory.
// [R9] Each window has its own width, timing, write protect and enable.
// [R10] Window start and stop are 4 KByte steps inside one 16 MByte page.
// [R11] The block is a host bus target only and never starts cycles.
// [R12] Four-socket mode shares one card address bus; two-socket mode has two sockets.
// [R13] Card address is window offset plus host address bits 23:12.
// [R14] Per-socket page register picks the 16 MByte page in 4 GByte.
// [R15] Space-select bit low means common memory, high means attribute memory.
// [R16] A window decodes only while its enable bit is set.
// [R17] Claim only when start <= host address <= stop inside the page.
// [R18] After reset the index holds no valid offset.
module pcwb_bridge
#(
   parameter NUM_WIN  = `PCWB_NUM_WIN,
   parameter ID_VALUE = 8'h5a
)
(
   input  wire        clk_sys,
   input  wire        nrst,
   input  wire        ce,
   input  wire [31:0] bridge_base,
   input  wire        strap_four_socket,
   input  wire [31:0] reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire [3:0]  reg_be,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output wire [31:0] reg_rdata,
   output reg         reg_claim,
   input  wire [31:0] mem_addr,
   input  wire        mem_req,
   output reg         mem_hit,
   output reg  [25:0] mem_card_addr,
   output reg         mem_attr,
   output reg  [1:0]  mem_socket,
   output reg  [2:0]  mem_window,
   output reg         mem_width16,
   output reg  [1:0]  mem_timing,
   output reg         mem_wp
);

   localparam NS  = `PCWB_NSOCK_MAX;
   localparam NWS = NS * NUM_WIN;

   // ID_VALUE default is arbitrary

   reg  [7:0]       index;
   reg              index_valid;
   reg  [7:0]       page_reg [0:NS-1];
   reg  [7:0]       wen_reg  [0:NS-1];
   reg              strap_s1;
   reg              strap_s2;
   reg  [1:0]       strap_cnt;
   reg              four_socket;
   reg              rd_q;
   reg              rd_dat_q;
   reg              rd_ram_q;
   reg  [7:0]       rd_byte_q;
   reg  [7:0]       rd_idx_q;
   reg  [1:0]       rd_lane_i_q;
   reg  [1:0]       rd_lane_d_q;
   reg  [7:0]       flop_byte;
   reg              any_hit;
   reg  [1:0]       pick_s;
   reg  [2:0]       pick_w;
   integer          s;
   integer          w;
   integer          k;
   wire             word_hit;
   wire [1:0]       lane_i;
   wire [1:0]       lane_d;
   wire             base_ok;
   wire             idx_we;
   wire             dat_wr_hit;
   wire             dat_we;
   wire             rd_claim;
   wire [7:0]       wb_i;
   wire [7:0]       wb_d;
   wire [2:0]       nsock;
   wire [7:0]       next_index;
   wire             next_valid;
   wire [1:0]       t_sock;
   wire [5:0]       t_reg;
   wire             t_win;
   wire [2:0]       t_wnum;
   wire             t_flop;
   wire [7:0]       ram_q;
   wire [7:0]       dat_byte;
   wire [NWS-1:0]   win_we;
   wire [NWS-1:0]   win_hit;
   wire [NWS-1:0]   win_attr;
   wire [NWS-1:0]   win_w16;
   wire [NWS-1:0]   win_wp;
   wire [2*NWS-1:0] win_tim;
   wire [14*NWS-1:0] win_card;
   wire [8*NWS-1:0] win_rd;
   wire [31:0]      t_k;
   wire [31:0]      p_k;

   function [7:0] lane_byte;
      input [31:0] wd;
      input [1:0]  ln;
      begin
         case (ln)
            2'd0:    lane_byte = wd[7:0];
            2'd1:    lane_byte = wd[15:8];
            2'd2:    lane_byte = wd[23:16];
            default: lane_byte = wd[31:24];
         endcase
      end
   endfunction

   function [31:0] place_byte;
      input [7:0] b;
      input [1:0] ln;
      begin
         case (ln)
            2'd0:    place_byte = {24'h000000, b};
            2'd1:    place_byte = {16'h0000, b, 8'h00};
            2'd2:    place_byte = {8'h00, b, 16'h0000};
            default: place_byte = {b, 24'h000000};
         endcase
      end
   endfunction

   // Offset is valid when its socket exists in this mode and the offset is mapped
   function idx_ok;
      input [7:0] x;
      input [2:0] n;
      begin
         idx_ok = ({1'b0, x[`PCWB_SOCK_FIELD]} < n) && (x[`PCWB_REG_FIELD] <= `PCWB_OFF_LAST); // R12
      end
   endfunction

   // Port decode; a base in lane 3 leaves the data port outside the word and unreachable
   assign word_hit   = reg_addr[`PCWB_WORD_FIELD] == bridge_base[`PCWB_WORD_FIELD]; // R1
   assign lane_i     = bridge_base[`PCWB_LANE_FIELD]; // R1
   assign lane_d     = lane_i + 2'd1; // R1
   assign base_ok    = lane_i != `PCWB_LANE_LAST;
   assign wb_i       = lane_byte(reg_wdata, lane_i); // R3
   assign wb_d       = lane_byte(reg_wdata, lane_d); // R3
   assign nsock      = four_socket ? `PCWB_NSOCK_FOUR : `PCWB_NSOCK_TWO; // R12
   assign idx_we     = reg_wr && word_hit && reg_be[lane_i]; // R5
   assign dat_wr_hit = reg_wr && word_hit && base_ok && reg_be[lane_d]; // R5
   // A combined write uses the index it carries, so the data byte lands on the new offset
   assign next_index = idx_we ? wb_i : index; // R3
   assign next_valid = idx_we ? idx_ok(wb_i, nsock) : index_valid; // R3
   assign dat_we     = dat_wr_hit && next_valid; // R4
   assign rd_claim   = reg_rd && word_hit && index_valid; // R4

   // Target register inside the socket configuration space
   assign t_sock = next_index[`PCWB_SOCK_FIELD]; // R2
   assign t_reg  = next_index[`PCWB_REG_FIELD]; // R2
   assign t_win  = (t_reg[`PCWB_WIN_GROUP] >= `PCWB_WIN_FIRST) && (t_reg <= `PCWB_OFF_LAST)
                   && (t_reg[`PCWB_WIN_SEL] <= `PCWB_WSEL_OFF_HI); // R6
   assign t_wnum = t_reg[`PCWB_WIN_GROUP] - `PCWB_WIN_FIRST;
   assign t_flop = t_win || (t_reg == `PCWB_OFF_ID) || (t_reg == `PCWB_OFF_STAT)
                   || (t_reg == `PCWB_OFF_PAGE) || (t_reg == `PCWB_OFF_WEN);
   assign t_k    = t_sock * NUM_WIN + t_wnum;

   // Interrupt and I/O mapping bytes are only stored here; nothing local acts on them
   pcwb_ram
   #(
      .AW (8),
      .DW (8)
   )
   u_ram
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ce      (ce),
      .we      (dat_we && !t_flop), // R6
      .waddr   (next_index),
      .wdata   (wb_d),
      .re      (rd_claim),
      .raddr   (index),
      .rdata   (ram_q)
   );

   genvar gs;
   genvar gw;
   generate
      for (gs = 0; gs < NS; gs = gs + 1)
      begin : g_sock
         for (gw = 0; gw < NUM_WIN; gw = gw + 1)
         begin : g_win
            assign win_we[gs*NUM_WIN+gw] = dat_we && t_win && (t_sock == gs) && (t_wnum == gw); // R7
            pcwb_window u_win
            (
               .clk_sys (clk_sys),
               .nrst    (nrst),
               .ce      (ce),
               .wr_en   (win_we[gs*NUM_WIN+gw]),
               .sel     (t_reg[`PCWB_WIN_SEL]),
               .wdata   (wb_d),
               .enable  (wen_reg[gs][gw]), // R16
               .page    (page_reg[gs]), // R14
               .haddr   (mem_addr),
               .hit     (win_hit[gs*NUM_WIN+gw]),
               .card_hi (win_card[14*(gs*NUM_WIN+gw) +: 14]),
               .attr    (win_attr[gs*NUM_WIN+gw]),
               .width16 (win_w16[gs*NUM_WIN+gw]),
               .timing  (win_tim[2*(gs*NUM_WIN+gw) +: 2]),
               .wp      (win_wp[gs*NUM_WIN+gw]),
               .rdata   (win_rd[8*(gs*NUM_WIN+gw) +: 8])
            );
         end
      end
   endgenerate

   // Readback of registers held in flops
   always @*
   begin
      case (t_reg)
         `PCWB_OFF_ID:   flop_byte = ID_VALUE;
         `PCWB_OFF_STAT: flop_byte = {four_socket, 6'h00, index_valid};
         `PCWB_OFF_PAGE: flop_byte = page_reg[t_sock];
         `PCWB_OFF_WEN:  flop_byte = wen_reg[t_sock];
         default:        flop_byte = win_rd[8*t_k +: 8];
      endcase
   end

   // Strap settles through two flops, then is caught once after reset release
   always @(posedge clk_sys)
   begin
      strap_s1 <= strap_four_socket;
      strap_s2 <= strap_s1;
   end

   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         strap_cnt   <= 2'd0;
         four_socket <= 1'b0;
      end
      else if (ce && (strap_cnt != `PCWB_LANE_LAST))
      begin
         strap_cnt <= strap_cnt + 2'd1;
         if (strap_cnt == `PCWB_STRAP_WAIT)
         begin
            four_socket <= strap_s2; // R12
         end
      end
   end

   // Register port state
   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         index       <= 8'h00;
         index_valid <= 1'b0; // R18
         reg_claim   <= 1'b0;
         rd_q        <= 1'b0;
         rd_dat_q    <= 1'b0;
         rd_ram_q    <= 1'b0;
         rd_byte_q   <= 8'h00;
         rd_idx_q    <= 8'h00;
         rd_lane_i_q <= 2'd0;
         rd_lane_d_q <= 2'd0;
         for (k = 0; k < NS; k = k + 1)
         begin
            page_reg[k] <= 8'h00;
            wen_reg[k]  <= 8'h00;
         end
      end
      else if (ce)
      begin
         if (idx_we)
         begin
            index       <= wb_i; // R2
            index_valid <= next_valid; // R2
         end
         if (dat_we && (t_reg == `PCWB_OFF_PAGE))
         begin
            page_reg[t_sock] <= wb_d; // R14
         end
         if (dat_we && (t_reg == `PCWB_OFF_WEN))
         begin
            wen_reg[t_sock] <= wb_d; // R16
         end
         reg_claim   <= rd_claim || idx_we || dat_we; // R4
         rd_q        <= rd_claim; // R4
         rd_dat_q    <= rd_claim && base_ok;
         rd_ram_q    <= !t_flop;
         rd_byte_q   <= flop_byte; // R5
         rd_idx_q    <= index; // R5
         rd_lane_i_q <= lane_i;
         rd_lane_d_q <= lane_d;
      end
   end

   // Read data stand only in the cycle after a claimed read; other lanes read zero
   assign dat_byte  = rd_ram_q ? ram_q : rd_byte_q;
   assign reg_rdata = rd_q ? (place_byte(rd_idx_q, rd_lane_i_q)
                              | (rd_dat_q ? place_byte(dat_byte, rd_lane_d_q) : 32'h00000000)) : 32'h00000000;

   // Lowest socket, then lowest window, wins when windows overlap
   always @*
   begin
      any_hit = 1'b0;
      pick_s  = 2'd0;
      pick_w  = 3'd0;
      for (s = NS - 1; s >= 0; s = s - 1)
      begin
         for (w = NUM_WIN - 1; w >= 0; w = w - 1)
         begin
            if (win_hit[s*NUM_WIN+w] && (s < nsock)) // R12
            begin
               any_hit = 1'b1;
               pick_s  = s[1:0];
               pick_w  = w[2:0];
            end
         end
      end
   end

   assign p_k = pick_s * NUM_WIN + pick_w;

   // Host side is target only: requests come in, a claim goes back, nothing is driven out
   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         mem_hit       <= 1'b0;
         mem_card_addr <= 26'h0000000;
         mem_attr      <= 1'b0;
         mem_socket    <= 2'd0;
         mem_window    <= 3'd0;
         mem_width16   <= 1'b0;
         mem_timing    <= 2'd0;
         mem_wp        <= 1'b0;
      end
      else if (ce)
      begin
         mem_hit <= mem_req && any_hit; // R11
         if (mem_req && any_hit)
         begin
            mem_card_addr <= {win_card[14*p_k +: 14], mem_addr[`PCWB_BYTE_FIELD]}; // R8
            mem_attr      <= win_attr[p_k]; // R15
            mem_socket    <= pick_s;
            mem_window    <= pick_w;
            mem_width16   <= win_w16[p_k]; // R9
            mem_timing    <= win_tim[2*p_k +: 2]; // R9
            mem_wp        <= win_wp[p_k]; // R9
         end
      end
   end

endmodule

// ===== pcwb_bridge_sva.sv
// Checker for the card window bridge: register port answers and window decode timing.
// Assumes it is bound to pcwb_bridge and sees only that module's ports.
`timescale 1ns/100ps

module pcwb_bridge_sva
#(
   parameter NUM_WIN  = 5,
   parameter ID_VALUE = 8'h5a
)
(
   input wire        clk_sys,
   input wire        nrst,
   input wire        ce,
   input wire [31:0] bridge_base,
   input wire        strap_four_socket,
   input wire [31:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire [3:0]  reg_be,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   input wire        reg_claim,
   input wire [31:0] mem_addr,
   input wire        mem_req,
   input wire        mem_hit,
   input wire [25:0] mem_card_addr,
   input wire        mem_attr,
   input wire [1:0]  mem_socket,
   input wire [2:0]  mem_window,
   input wire        mem_width16,
   input wire [1:0]  mem_timing,
   input wire        mem_wp
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   property p_claim_addr;
      reg_claim |-> $past(reg_addr[31:2]) == $past(bridge_base[31:2]);
   endproperty
   a_claim_addr: assert property (p_claim_addr)
      else $error("Claim for an address off the port pair");
   property p_claim_quiet;
      !(ce && (reg_rd || reg_wr)) |=> !reg_claim;
   endproperty
   a_claim_quiet: assert property (p_claim_quiet)
      else $error("Claim without a request");
   property p_rdata_zero;
      !(reg_claim && $past(reg_rd)) |-> reg_rdata == 32'h0;
   endproperty
   a_rdata_zero: assert property (p_rdata_zero)
      else $error("Read data outside a claimed read");
   property p_hit_quiet;
      !(ce && mem_req) |=> !mem_hit;
   endproperty
   a_hit_quiet: assert property (p_hit_quiet)
      else $error("Window hit without a decode request");
   property p_hit_low;
      mem_hit |-> mem_card_addr[11:0] == $past(mem_addr[11:0]);
   endproperty
   a_hit_low: assert property (p_hit_low)
      else $error("Card address low bits not passed through");
   property p_window_range;
      mem_hit |-> mem_window < NUM_WIN;
   endproperty
   a_window_range: assert property (p_window_range)
      else $error("Window number out of range");
   property p_socket_range;
      mem_hit |-> (strap_four_socket || mem_socket < 2'd2);
   endproperty
   a_socket_range: assert property (p_socket_range)
      else $error("Socket beyond the two-socket count");
   // Reset clears the held fields, so the first edge after release is exempt
   property p_held;
      !mem_hit && $past(nrst) |-> $stable(mem_card_addr) && $stable(mem_attr) && $stable(mem_window);
   endproperty
   a_held: assert property (p_held)
      else $error("Held window fields moved without a hit");
endmodule

bind pcwb_bridge pcwb_bridge_sva #(.NUM_WIN(NUM_WIN), .ID_VALUE(ID_VALUE)) i_pcwb_bridge_sva
(
   .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .bridge_base(bridge_base),
   .strap_four_socket(strap_four_socket), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_claim(reg_claim),
   .mem_addr(mem_addr), .mem_req(mem_req), .mem_hit(mem_hit), .mem_card_addr(mem_card_addr),
   .mem_attr(mem_attr), .mem_socket(mem_socket), .mem_window(mem_window),
   .mem_width16(mem_width16), .mem_timing(mem_timing), .mem_wp(mem_wp)
);

// ===== pcwb_card_model.sv
// Card side stand-in: tallies decoded accesses by memory space.
// Assumes mem_hit qualifies the held card fields in the cycle it is high.
`timescale 1ns/100ps

module pcwb_card_model
(
   input  wire        clk_sys,
   input  wire        mem_hit,
   input  wire [25:0] mem_card_addr,
   input  wire        mem_attr,
   output integer     n_common,
   output integer     n_attr,
   output reg  [25:0] last_addr
);
   initial
   begin
      n_common = 0;
      n_attr = 0;
      last_addr = 26'h0;
   end
   // Space counts and the last card address are kept; card data cycles are outside this block
   always @(posedge clk_sys)
   begin
      if (mem_hit === 1'b1)
      begin
         last_addr <= mem_card_addr;
         if (mem_attr === 1'b1)
            n_attr <= n_attr + 1;
         else
            n_common <= n_common + 1;
      end
   end
endmodule

// ===== tb_pcwb_bridge.sv
// Self-checking bench for the card window bridge: indexed register access and window decode.
// Assumes a card tally model beside the bridge; clock enable drops once and a second reset raises the strap.
`timescale 1ns/100ps

module tb_pcwb_bridge;
   localparam [31:0] BASE    = 32'h0000_1000;
   localparam [95:0] WIN_TAB = 96'h0083ff4310c1_0005ff050000;
   reg         clk_sys;
   reg         nrst;
   reg  [31:0] bridge_base;
   reg  [31:0] reg_addr;
   reg  [31:0] reg_wdata;
   reg  [3:0]  reg_be;
   reg         reg_wr;
   reg         reg_rd;
   reg  [31:0] mem_addr;
   reg         mem_req;
   reg         ce;
   reg         strap_four_socket;
   wire [31:0] reg_rdata;
   wire        reg_claim;
   wire        mem_hit;
   wire [25:0] mem_card_addr;
   wire        mem_attr;
   wire [1:0]  mem_socket;
   wire [2:0]  mem_window;
   wire        mem_width16;
   wire [1:0]  mem_timing;
   wire        mem_wp;
   integer     n_common;
   integer     n_attr;
   integer     n_errors;
   integer     n_checks;
   integer     w;

   pcwb_bridge i_pcwb_bridge
   (
      .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .bridge_base(bridge_base), .strap_four_socket(strap_four_socket),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_claim(reg_claim), .mem_addr(mem_addr), .mem_req(mem_req),
      .mem_hit(mem_hit), .mem_card_addr(mem_card_addr), .mem_attr(mem_attr), .mem_socket(mem_socket),
      .mem_window(mem_window), .mem_width16(mem_width16), .mem_timing(mem_timing), .mem_wp(mem_wp)
   );
   pcwb_card_model i_pcwb_card_model
   (
      .clk_sys(clk_sys), .mem_hit(mem_hit), .mem_card_addr(mem_card_addr), .mem_attr(mem_attr),
      .n_common(n_common), .n_attr(n_attr), .last_addr()
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   // One strobe cycle; claim and read data are looked at in the cycle after only
   task bus(input rd, input [31:0] a, input [31:0] d, input [3:0] be, input claim, input [31:0] rdat);
   begin
      @(posedge clk_sys);
      reg_rd <= rd;
      reg_wr <= !rd;
      reg_addr <= a;
      reg_wdata <= d;
      reg_be <= be;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      #1;
      chk(32'(reg_claim), 32'(claim));
      if (rd)
         chk(reg_rdata, rdat);
   end
   endtask

   task setreg(input [7:0] idx, input [7:0] val);
      bus(1'b0, BASE, {16'h0, val, idx}, 4'h3, 1'b1, 32'h0);
   endtask

   task getreg(input [7:0] idx, input [7:0] val);
   begin
      bus(1'b0, BASE, {24'h0, idx}, 4'h1, 1'b1, 32'h0);
      bus(1'b1, BASE, 32'h0, 4'h0, 1'b1, {16'h0, val, idx});
   end
   endtask

   // attrs packs socket, space, width, timing, write protect and window
   task mreq(input [31:0] a, input hit, input [25:0] card, input [9:0] attrs);
   begin
      @(posedge clk_sys);
      mem_req <= 1'b1;
      mem_addr <= a;
      @(posedge clk_sys);
      mem_req <= 1'b0;
      #1;
      chk(32'(mem_hit), 32'(hit));
      if (hit)
      begin
         chk(32'(mem_card_addr), 32'(card));
         chk(32'({mem_socket, mem_attr, mem_width16, mem_timing, mem_wp, mem_window}), 32'(attrs));
      end
   end
   endtask

   task wrap_up;
   begin
      $display("Checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask

   // Whole run is about 135 cycles; this limit is 10000 cycles, over seventy times that
   initial
   begin
      #100000;
      n_errors = n_errors + 1;
      wrap_up;
   end

   initial
   begin
      n_errors = 0;
      n_checks = 0;
      nrst = 1'b0;
      bridge_base = BASE;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      reg_be = 4'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      mem_addr = 32'h0;
      mem_req = 1'b0;
      ce = 1'b1;
      strap_four_socket = 1'b0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      // Mode strap is taken a few edges after release
      repeat (4) @(posedge clk_sys);
      #1;
      chk({reg_claim, mem_hit, reg_rdata[29:0]}, 32'h0);
      bus(1'b1, BASE, 32'h0, 4'h0, 1'b0, 32'h0);
      bus(1'b0, BASE, 32'h0000_3300, 4'h2, 1'b0, 32'h0);
      bus(1'b0, BASE, 32'h0000_0005, 4'h1, 1'b1, 32'h0);
      bus(1'b0, BASE, 32'h0000_1200, 4'h2, 1'b1, 32'h0);
      bus(1'b1, BASE, 32'h0, 4'h0, 1'b1, 32'h0000_1205);
      setreg(8'h06, 8'h01);
      getreg(8'h06, 8'h01);
      setreg(8'h00, 8'hff);
      getreg(8'h00, 8'h5a);
      getreg(8'h01, 8'h01);
      setreg(8'h03, 8'ha5);
      getreg(8'h03, 8'ha5);
      setreg(8'h05, 8'h12);
      for (w = 0; w < 6; w = w + 1)
      begin
         setreg(8'h10 + w[7:0], WIN_TAB[95 - 8 * w -: 8]);
         setreg(8'h30 + w[7:0], WIN_TAB[47 - 8 * w -: 8]);
      end
      setreg(8'h06, 8'h11);
      mreq(32'h1230_0abc, 1'b1, 26'h0410abc, 10'h0d8);
      mreq(32'h123f_f000, 1'b1, 26'h050f000, 10'h0d8);
      mreq(32'h122f_ffff, 1'b0, 26'h0, 10'h0);
      mreq(32'h1240_0000, 1'b0, 26'h0, 10'h0);
      mreq(32'h1330_0abc, 1'b0, 26'h0, 10'h0);
      mreq(32'h1250_0004, 1'b1, 26'h0500004, 10'h004);
      setreg(8'h06, 8'h10);
      mreq(32'h1230_0abc, 1'b0, 26'h0, 10'h0);
      mreq(32'h125f_f008, 1'b1, 26'h05ff008, 10'h004);
      @(posedge clk_sys);
      #1;
      chk(n_attr, 32'd2);
      chk(n_common, 32'd2);
      setreg(8'h45, 8'h34);
      getreg(8'h45, 8'h34);
      bus(1'b0, BASE, 32'h0000_0085, 4'h1, 1'b1, 32'h0);
      bus(1'b1, BASE, 32'h0, 4'h0, 1'b0, 32'h0);
      bus(1'b0, BASE, 32'h0000_0038, 4'h1, 1'b1, 32'h0);
      bus(1'b1, BASE, 32'h0, 4'h0, 1'b0, 32'h0);
      @(posedge clk_sys);
      bridge_base <= 32'h0000_2002;
      bus(1'b0, 32'h0000_2002, 32'h7703_0000, 4'hc, 1'b1, 32'h0);
      bus(1'b1, 32'h0000_2000, 32'h0, 4'h0, 1'b1, 32'h7703_0000);
      bus(1'b1, BASE, 32'h0, 4'h0, 1'b0, 32'h0);
      // Clock enable low must leave the stored index untouched
      @(posedge clk_sys);
      ce <= 1'b0;
      bus(1'b0, 32'h0000_2002, 32'h0005_0000, 4'h4, 1'b0, 32'h0);
      @(posedge clk_sys);
      ce <= 1'b1;
      bus(1'b1, 32'h0000_2000, 32'h0, 4'h0, 1'b1, 32'h7703_0000);
      // Second reset with the strap high selects four sockets
      @(posedge clk_sys);
      strap_four_socket <= 1'b1;
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bridge_base <= BASE;
      bus(1'b1, BASE, 32'h0, 4'h0, 1'b0, 32'h0);
      getreg(8'h01, 8'h81);
      setreg(8'h85, 8'h56);
      getreg(8'h85, 8'h56);
      wrap_up;
   end
endmodule
